// ==== design/gpibtl_pkg.sv ====
// Constants, command codes and state types of the GPIB talker/listener port
package gpibtl_pkg;

  // Bus command codes, seven bits, parity bit ignored
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3f;
  localparam logic [6:0] CMD_UNT = 7'h5f;
  localparam logic [1:0] LISTEN_GROUP = 2'h1;
  localparam logic [1:0] TALK_GROUP   = 2'h2;

  // Field widths, bit position and buffer depth
  localparam int ADDR_W   = 5;
  localparam int RQS_BIT  = 6;
  localparam int FIFO_W   = 9;
  localparam int FIFO_D   = 8;
  localparam int SYNC_W   = 16;

  // Trigger source encodings
  localparam logic [1:0] TRIG_SRC_IMM = 2'h0;
  localparam logic [1:0] TRIG_SRC_BUS = 2'h1;
  localparam logic [1:0] TRIG_SRC_EXT = 2'h2;

  // Data settling time before data valid is asserted
  localparam int CLK_PERIOD_NS = 100;
  localparam int SETTLE_NS     = 2000;
  localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int SETTLE_W      = 5;

  // Reset values
  localparam logic [SYNC_W-1:0] SYNC_RST = 16'h7fff;

  typedef enum logic [4:0] {
    AH_IDLE = 5'h01,
    AH_NRDY = 5'h02,
    AH_RDY  = 5'h04,
    AH_ACC  = 5'h08,
    AH_WAIT = 5'h10
  } gpibtl_ah_t;

  typedef enum logic [4:0] {
    SH_IDLE   = 5'h01,
    SH_SETTLE = 5'h02,
    SH_WRFD   = 5'h04,
    SH_DAV    = 5'h08,
    SH_REL    = 5'h10
  } gpibtl_sh_t;

endpackage : gpibtl_pkg

// ==== design/gpibtl_fifo.sv ====
// Receive FIFO with width and depth parameters and valid/ready on both sides
`timescale 1ns/10ps
module gpibtl_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic             flush_i,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  // Drain side
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ff;
  logic [AW:0]      rd_ff;
  logic [AW:0]      nxt_wr;
  logic [AW:0]      nxt_rd;
  logic             push;
  logic             pop;

  assign in_ready_o  = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_ff != rd_ff;
  assign out_data_o  = mem_ff[rd_ff[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
    if (flush_i) begin
      nxt_wr = '0;
      nxt_rd = '0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ff[AW-1:0]] <= in_data_i;
    end
  end

endmodule : gpibtl_fifo

// ==== design/gpibtl_port.sv ====
// GPIB talker/listener interface logic of the instrument
`timescale 1ns/10ps
module gpibtl_port (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // Bus data lines, active low, open drain
  input  wire logic [7:0]  dio_n_i,
  output logic      [7:0]  dio_n_o,
  output logic      [7:0]  dio_oe_o,
  // Bus handshake and management lines
  input  wire logic        dav_n_i,
  output logic             dav_n_o,
  output logic             dav_oe_o,
  input  wire logic        nrfd_n_i,
  output logic             nrfd_n_o,
  output logic             nrfd_oe_o,
  input  wire logic        ndac_n_i,
  output logic             ndac_n_o,
  output logic             ndac_oe_o,
  input  wire logic        eoi_n_i,
  output logic             eoi_n_o,
  output logic             eoi_oe_o,
  input  wire logic        srq_n_i,
  output logic             srq_n_o,
  output logic             srq_oe_o,
  input  wire logic        atn_n_i,
  input  wire logic        ifc_n_i,
  input  wire logic        ren_n_i,
  // Configuration
  input  wire logic [4:0]  addr_i,
  // Received data stream
  output logic      [7:0]  rx_data_o,
  output logic             rx_end_o,
  output logic             rx_valid_o,
  input  wire logic        rx_ready_i,
  // Transmit data stream
  input  wire logic [7:0]  tx_data_i,
  input  wire logic        tx_end_i,
  input  wire logic        tx_valid_i,
  output logic             tx_ready_o,
  // Status and service request
  input  wire logic [7:0]  status_i,
  input  wire logic [7:0]  srq_cond_i,
  input  wire logic [7:0]  srq_enable_i,
  // Front panel and command parser
  input  wire logic        key_valid_i,
  input  wire logic        key_local_i,
  input  wire logic        lockout_i,
  input  wire logic        rem_cmd_valid_i,
  input  wire logic        rem_cmd_arg_i,
  input  wire logic [1:0]  trig_source_i,
  input  wire logic        trig_cmd_i,
  input  wire logic        ext_trig_i,
  // Device events and state
  output logic             key_accept_o,
  output logic             trigger_o,
  output logic             dev_clear_o,
  output logic             remote_o,
  output logic             talker_o,
  output logic             listener_o,
  output logic             spoll_o
);

  // Input synchronisers
  logic [15:0] sync1_ff;
  logic [15:0] sync2_ff;
  logic [15:0] raw_in;
  logic [15:0] nxt_sync1;
  logic [15:0] nxt_sync2;

  assign raw_in = {ext_trig_i, atn_n_i, ifc_n_i, ren_n_i, dav_n_i,
                   nrfd_n_i, ndac_n_i, eoi_n_i, dio_n_i};

  always_comb begin
    nxt_sync1 = raw_in;
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_ff <= gpibtl_pkg::SYNC_RST;
      sync2_ff <= gpibtl_pkg::SYNC_RST;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  // Logical (true = asserted) bus levels
  logic       ext_trig;
  logic       atn;
  logic       ifc;
  logic       ren;
  logic       dav;
  logic       nrfd;
  logic       ndac;
  logic       eoi;
  logic [7:0] dio;
  logic       srq_unused;

  assign ext_trig   = sync2_ff[15];
  assign atn        = !sync2_ff[14];
  assign ifc        = !sync2_ff[13];
  assign ren        = !sync2_ff[12];
  assign dav        = !sync2_ff[11];
  assign nrfd       = !sync2_ff[10];
  assign ndac       = !sync2_ff[9];
  assign eoi        = !sync2_ff[8];
  assign dio        = ~sync2_ff[7:0];
  assign srq_unused = srq_n_i;

  // Receive FIFO
  logic fifo_in_ready;
  logic fifo_in_valid;
  logic fifo_flush;
  logic [gpibtl_pkg::FIFO_W-1:0] fifo_out;

  // Acceptor handshake
  gpibtl_pkg::gpibtl_ah_t ah_ff;
  gpibtl_pkg::gpibtl_ah_t nxt_ah;
  logic [7:0] rx_byte_ff;
  logic [7:0] nxt_rx_byte;
  logic       rx_eoi_ff;
  logic       nxt_rx_eoi;
  logic       rx_atn_ff;
  logic       nxt_rx_atn;
  logic       ah_active;

  // Commands are taken by everyone while attention is true
  assign ah_active = atn || listener_o;

  always_comb begin
    nxt_ah      = ah_ff;
    nxt_rx_byte = rx_byte_ff;
    nxt_rx_eoi  = rx_eoi_ff;
    nxt_rx_atn  = rx_atn_ff;
    case (ah_ff)
      gpibtl_pkg::AH_IDLE: begin
        if (ah_active) begin
          nxt_ah = gpibtl_pkg::AH_NRDY;
        end
      end
      gpibtl_pkg::AH_NRDY: begin
        if (!ah_active) begin
          nxt_ah = gpibtl_pkg::AH_IDLE;
        end else if ((atn || fifo_in_ready) && !dav) begin
          nxt_ah = gpibtl_pkg::AH_RDY;
        end
      end
      gpibtl_pkg::AH_RDY: begin
        if (!ah_active) begin
          nxt_ah = gpibtl_pkg::AH_IDLE;
        end else if (dav) begin
          nxt_ah      = gpibtl_pkg::AH_ACC;
          nxt_rx_byte = dio;
          nxt_rx_eoi  = eoi;
          nxt_rx_atn  = atn;
        end
      end
      gpibtl_pkg::AH_ACC: begin
        nxt_ah = gpibtl_pkg::AH_WAIT;
      end
      gpibtl_pkg::AH_WAIT: begin
        if (!dav) begin
          nxt_ah = ah_active ? gpibtl_pkg::AH_NRDY : gpibtl_pkg::AH_IDLE;
        end
      end
      default: begin
        nxt_ah = gpibtl_pkg::AH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ah_ff      <= gpibtl_pkg::AH_IDLE;
      rx_byte_ff <= 8'h00;
      rx_eoi_ff  <= 1'b0;
      rx_atn_ff  <= 1'b0;
    end else begin
      ah_ff      <= nxt_ah;
      rx_byte_ff <= nxt_rx_byte;
      rx_eoi_ff  <= nxt_rx_eoi;
      rx_atn_ff  <= nxt_rx_atn;
    end
  end

  // Command decode of an accepted byte sent under attention
  logic       cmd_take;
  logic [6:0] cmd;
  logic       is_mla;
  logic       is_mta;
  logic       is_ota;

  assign cmd_take = (ah_ff == gpibtl_pkg::AH_ACC) && rx_atn_ff;
  assign cmd      = rx_byte_ff[6:0];
  assign is_mla   = cmd == {gpibtl_pkg::LISTEN_GROUP, addr_i};
  assign is_mta   = cmd == {gpibtl_pkg::TALK_GROUP, addr_i};
  assign is_ota   = (cmd[6:5] == gpibtl_pkg::TALK_GROUP) && !is_mta
                    && (cmd != gpibtl_pkg::CMD_UNT);
  assign fifo_in_valid = (ah_ff == gpibtl_pkg::AH_ACC) && !rx_atn_ff
                         && listener_o;

  // Source handshake
  gpibtl_pkg::gpibtl_sh_t sh_ff;
  gpibtl_pkg::gpibtl_sh_t nxt_sh;
  logic [7:0]                      tx_byte_ff;
  logic [7:0]                      nxt_tx_byte;
  logic                            tx_eoi_ff;
  logic                            nxt_tx_eoi;
  logic                            tx_stb_ff;
  logic                            nxt_tx_stb;
  logic [gpibtl_pkg::SETTLE_W-1:0] settle_ff;
  logic [gpibtl_pkg::SETTLE_W-1:0] nxt_settle;
  logic                            talk_data;
  logic                            stb_sent;
  logic                            srq_pend_ff;

  assign talk_data  = talker_o && !atn;
  assign tx_ready_o = (sh_ff == gpibtl_pkg::SH_IDLE) && talk_data
                      && !spoll_o;
  assign stb_sent   = (sh_ff == gpibtl_pkg::SH_DAV) && !ndac && tx_stb_ff
                      && tx_byte_ff[gpibtl_pkg::RQS_BIT];

  always_comb begin
    nxt_sh      = sh_ff;
    nxt_tx_byte = tx_byte_ff;
    nxt_tx_eoi  = tx_eoi_ff;
    nxt_tx_stb  = tx_stb_ff;
    nxt_settle  = settle_ff;
    case (sh_ff)
      gpibtl_pkg::SH_IDLE: begin
        nxt_settle = '0;
        if (talk_data && spoll_o) begin
          nxt_sh      = gpibtl_pkg::SH_SETTLE;
          nxt_tx_byte = status_i;
          nxt_tx_byte[gpibtl_pkg::RQS_BIT] = srq_pend_ff;
          nxt_tx_eoi  = 1'b0;
          nxt_tx_stb  = 1'b1;
        end else if (talk_data && tx_valid_i) begin
          nxt_sh      = gpibtl_pkg::SH_SETTLE;
          nxt_tx_byte = tx_data_i;
          nxt_tx_eoi  = tx_end_i;
          nxt_tx_stb  = 1'b0;
        end
      end
      gpibtl_pkg::SH_SETTLE: begin
        nxt_settle = settle_ff + 1'b1;
        if (settle_ff == gpibtl_pkg::SETTLE_W'(gpibtl_pkg::SETTLE_CYC - 1))
        begin
          nxt_sh = gpibtl_pkg::SH_WRFD;
        end
      end
      gpibtl_pkg::SH_WRFD: begin
        if (!nrfd) begin
          nxt_sh = gpibtl_pkg::SH_DAV;
        end
      end
      gpibtl_pkg::SH_DAV: begin
        if (!ndac) begin
          nxt_sh = gpibtl_pkg::SH_REL;
        end
      end
      gpibtl_pkg::SH_REL: begin
        nxt_sh = gpibtl_pkg::SH_IDLE;
      end
      default: begin
        nxt_sh = gpibtl_pkg::SH_IDLE;
      end
    endcase
    // Attention or loss of talk role withdraws the byte at once
    if (!talk_data || fifo_flush) begin
      nxt_sh = gpibtl_pkg::SH_IDLE;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sh_ff      <= gpibtl_pkg::SH_IDLE;
      tx_byte_ff <= 8'h00;
      tx_eoi_ff  <= 1'b0;
      tx_stb_ff  <= 1'b0;
      settle_ff  <= '0;
    end else begin
      sh_ff      <= nxt_sh;
      tx_byte_ff <= nxt_tx_byte;
      tx_eoi_ff  <= nxt_tx_eoi;
      tx_stb_ff  <= nxt_tx_stb;
      settle_ff  <= nxt_settle;
    end
  end

  // Addressing, remote/local, service request and device events
  logic talk_ff;
  logic listen_ff;
  logic spoll_ff;
  logic remote_ff;
  logic srq_any_ff;
  logic ext_prev_ff;
  logic trig_ff;
  logic clear_ff;
  logic key_ff;
  logic nxt_talk;
  logic nxt_listen;
  logic nxt_spoll;
  logic nxt_remote;
  logic nxt_srq_pend;
  logic nxt_srq_any;
  logic nxt_trig;
  logic nxt_clear;
  logic nxt_key;
  logic srq_any;
  logic get_hit;

  assign srq_any = |(srq_cond_i & srq_enable_i);
  assign get_hit = cmd_take && listen_ff && (cmd == gpibtl_pkg::CMD_GET);

  always_comb begin
    nxt_talk    = talk_ff;
    nxt_listen  = listen_ff;
    nxt_spoll   = spoll_ff;
    nxt_remote  = remote_ff;
    nxt_srq_any = srq_any;
    if (cmd_take) begin
      if (is_mla) begin
        nxt_listen = 1'b1;
        nxt_talk   = 1'b0;
        nxt_remote = remote_ff || ren;
      end
      if (is_mta) begin
        nxt_talk   = 1'b1;
        nxt_listen = 1'b0;
      end
      if (is_ota || cmd == gpibtl_pkg::CMD_UNT) begin
        nxt_talk = 1'b0;
      end
      if (cmd == gpibtl_pkg::CMD_UNL) begin
        nxt_listen = 1'b0;
      end
      if (cmd == gpibtl_pkg::CMD_SPE) begin
        nxt_spoll = 1'b1;
      end
      if (cmd == gpibtl_pkg::CMD_SPD) begin
        nxt_spoll = 1'b0;
      end
      // Go-to-local is deliberately not decoded
    end
    if (ifc) begin
      nxt_talk   = 1'b0;
      nxt_listen = 1'b0;
      nxt_spoll  = 1'b0;
    end
    if (rem_cmd_valid_i) begin
      nxt_remote = rem_cmd_arg_i;
    end
    if (key_valid_i && key_local_i && !lockout_i) begin
      nxt_remote = 1'b0;
    end
    if (!ren) begin
      nxt_remote = 1'b0;
    end
    // First enabled condition after none sets the request; a set beats the poll clear
    nxt_srq_pend = srq_pend_ff;
    if (stb_sent) begin
      nxt_srq_pend = 1'b0;
    end
    if (srq_any && !srq_any_ff) begin
      nxt_srq_pend = 1'b1;
    end
    nxt_clear = cmd_take && ((cmd == gpibtl_pkg::CMD_DCL)
                || (listen_ff && cmd == gpibtl_pkg::CMD_SDC));
    case (trig_source_i)
      gpibtl_pkg::TRIG_SRC_BUS: nxt_trig = get_hit || trig_cmd_i;
      gpibtl_pkg::TRIG_SRC_EXT: nxt_trig = ext_trig && !ext_prev_ff;
      gpibtl_pkg::TRIG_SRC_IMM: nxt_trig = trig_cmd_i;
      default:                  nxt_trig = 1'b0;
    endcase
    nxt_key = key_valid_i
              && (!remote_ff || (key_local_i && !lockout_i));
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      talk_ff     <= 1'b0;
      listen_ff   <= 1'b0;
      spoll_ff    <= 1'b0;
      remote_ff   <= 1'b0;
      srq_pend_ff <= 1'b0;
      srq_any_ff  <= 1'b0;
      ext_prev_ff <= 1'b0;
      trig_ff     <= 1'b0;
      clear_ff    <= 1'b0;
      key_ff      <= 1'b0;
    end else begin
      talk_ff     <= nxt_talk;
      listen_ff   <= nxt_listen;
      spoll_ff    <= nxt_spoll;
      remote_ff   <= nxt_remote;
      srq_pend_ff <= nxt_srq_pend;
      srq_any_ff  <= nxt_srq_any;
      ext_prev_ff <= ext_trig;
      trig_ff     <= nxt_trig;
      clear_ff    <= nxt_clear;
      key_ff      <= nxt_key;
    end
  end

  assign fifo_flush = clear_ff;

  gpibtl_fifo #(
    .WIDTH (gpibtl_pkg::FIFO_W),
    .DEPTH (gpibtl_pkg::FIFO_D)
  ) u_rx_fifo (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .flush_i     (fifo_flush),
    .in_data_i   ({rx_eoi_ff, rx_byte_ff}),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i)
  );

  // Pin drive: outputs pull low only while enabled
  logic sh_drive;

  assign sh_drive  = (sh_ff == gpibtl_pkg::SH_SETTLE)
                     || (sh_ff == gpibtl_pkg::SH_WRFD)
                     || (sh_ff == gpibtl_pkg::SH_DAV);
  assign dio_n_o   = 8'h00;
  assign dio_oe_o  = sh_drive ? tx_byte_ff : 8'h00;
  assign eoi_n_o   = 1'b0;
  assign eoi_oe_o  = sh_drive && tx_eoi_ff;
  assign dav_n_o   = 1'b0;
  assign dav_oe_o  = sh_ff == gpibtl_pkg::SH_DAV;
  assign nrfd_n_o  = 1'b0;
  assign nrfd_oe_o = (ah_ff == gpibtl_pkg::AH_NRDY)
                     || (ah_ff == gpibtl_pkg::AH_ACC)
                     || (ah_ff == gpibtl_pkg::AH_WAIT);
  assign ndac_n_o  = 1'b0;
  assign ndac_oe_o = (ah_ff == gpibtl_pkg::AH_NRDY)
                     || (ah_ff == gpibtl_pkg::AH_RDY);
  assign srq_n_o   = 1'b0;
  assign srq_oe_o  = srq_pend_ff;

  assign rx_data_o    = fifo_out[7:0];
  assign rx_end_o     = fifo_out[8];
  assign key_accept_o = key_ff;
  assign trigger_o    = trig_ff;
  assign dev_clear_o  = clear_ff;
  assign remote_o     = remote_ff;
  assign talker_o     = talk_ff;
  assign listener_o   = listen_ff;
  assign spoll_o      = spoll_ff;

endmodule : gpibtl_port

// ==== sim/gpibtl_port_assertions.sv ====
// Concurrent checks on the ports of the GPIB talker/listener port
`timescale 1ns/10ps
module gpibtl_chk (
  // Clock, reset and bus lines
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire logic       dav_n_i,
  input wire logic       nrfd_n_i,
  input wire logic       ndac_n_i,
  input wire logic       ren_n_i,
  // Bus line enables
  input wire logic       dav_oe_o,
  input wire logic       nrfd_oe_o,
  input wire logic       ndac_oe_o,
  input wire logic       srq_oe_o,
  // Device side
  input wire logic [7:0] srq_cond_i,
  input wire logic [7:0] srq_enable_i,
  input wire logic       key_valid_i,
  input wire logic       key_local_i,
  input wire logic       lockout_i,
  input wire logic       rem_cmd_valid_i,
  input wire logic [1:0] trig_source_i,
  input wire logic       trig_cmd_i,
  input wire logic       key_accept_o,
  input wire logic       trigger_o,
  input wire logic       remote_o,
  input wire logic       talker_o,
  input wire logic       listener_o,
  input wire logic       spoll_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_srq_raise: assert property (
    $rose(|(srq_cond_i & srq_enable_i)) |=> srq_oe_o)
    else $error("service request not raised");
  a_srq_held: assert property (
    srq_oe_o && !spoll_o |=> srq_oe_o)
    else $error("service request dropped without poll");
  a_dav_after_rfd: assert property (
    $rose(dav_oe_o) |-> $past(nrfd_n_i, 3))
    else $error("data valid before ready for data");
  a_dav_hold: assert property (
    dav_oe_o && !ndac_n_i |=> dav_oe_o)
    else $error("data valid removed before accepted");
  a_accept_dav: assert property (
    $fell(ndac_oe_o) && nrfd_oe_o |-> !$past(dav_n_i, 2))
    else $error("data accepted without data valid");
  a_ready_idle: assert property (
    $fell(nrfd_oe_o) && ndac_oe_o |-> $past(dav_n_i, 2))
    else $error("ready for data while data valid");
  a_one_role: assert property (
    !(talker_o && listener_o))
    else $error("talker and listener at once");
  a_remote_keys: assert property (
    key_valid_i && remote_o && !key_local_i |=> !key_accept_o)
    else $error("key accepted in remote");
  a_lockout_hold: assert property (
    key_valid_i && remote_o && lockout_i && !rem_cmd_valid_i
      && !ren_n_i |=> remote_o && !key_accept_o)
    else $error("locked local key acted");
  a_local_keys: assert property (
    key_valid_i && !remote_o |=> key_accept_o)
    else $error("key ignored in local");
  a_bus_trigger: assert property (
    trig_cmd_i && trig_source_i == gpibtl_pkg::TRIG_SRC_BUS |=> trigger_o)
    else $error("trigger command not executed");
endmodule : gpibtl_chk

// ==== sim/gpibtl_host.sv ====
// Host controller model: bus source and acceptor
`timescale 1ns/10ps
module gpibtl_host (
  // Bus lines as seen on the cable
  input  wire logic       clk_i,
  input  wire logic       nrfd_n_i,
  input  wire logic       ndac_n_i,
  input  wire logic       dav_n_i,
  input  wire logic       eoi_n_i,
  input  wire logic [7:0] dio_n_i,
  // Pull enables, high pulls the line low
  output logic            atn_o,
  output logic            dav_o,
  output logic            nrfd_o,
  output logic            ndac_o,
  output logic            eoi_o,
  output logic      [7:0] dio_o
);
  initial {atn_o, dav_o, nrfd_o, ndac_o, eoi_o, dio_o} = '0;

  // Sends one byte, under attention when cmd is set
  task put(input logic [7:0] b, input logic cmd, input logic e);
    @(posedge clk_i);
    atn_o  <= cmd;
    nrfd_o <= 1'b0;
    ndac_o <= 1'b0;
    dio_o  <= b;
    eoi_o  <= e;
    repeat (4) @(posedge clk_i);
    while (!nrfd_n_i) @(posedge clk_i);
    dav_o <= 1'b1;
    @(posedge clk_i);
    while (!ndac_n_i) @(posedge clk_i);
    dav_o <= 1'b0;
    dio_o <= 8'h00;
    eoi_o <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : put

  // Accepts one byte, holding data accepted off for dly cycles
  task get(output logic [7:0] b, output logic e, input int dly);
    @(posedge clk_i);
    atn_o  <= 1'b0;
    ndac_o <= 1'b1;
    nrfd_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    nrfd_o <= 1'b0;
    @(posedge clk_i);
    while (dav_n_i) @(posedge clk_i);
    b = ~dio_n_i;
    e = ~eoi_n_i;
    nrfd_o <= 1'b1;
    repeat (dly) @(posedge clk_i);
    ndac_o <= 1'b0;
    @(posedge clk_i);
    while (!dav_n_i) @(posedge clk_i);
    ndac_o <= 1'b1;
  endtask : get
endmodule : gpibtl_host

// ==== sim/testbench.sv ====
// Self-checking testbench of the GPIB talker/listener port
`timescale 1ns/10ps
module testbench;
  localparam logic [4:0] ADDR = 5'h0b;
  localparam logic [7:0] STB  = 8'h13;
  logic       clk_i, resetn_i, ifc_n_i, ren_n_i, atn_n_i;
  logic [7:0] dio_n_i, dio_n_o, dio_oe_o, rx_data_o, tx_data_i, dio_o;
  logic       dav_n_i, dav_n_o, dav_oe_o, nrfd_n_i, nrfd_n_o, nrfd_oe_o;
  logic       ndac_n_i, ndac_n_o, ndac_oe_o, eoi_n_i, eoi_n_o, eoi_oe_o;
  logic       srq_n_i, srq_n_o, srq_oe_o, rx_end_o, rx_valid_o, rx_ready_i;
  logic [4:0] addr_i;
  logic       tx_end_i, tx_valid_i, tx_ready_o, key_valid_i, key_local_i;
  logic [7:0] status_i, srq_cond_i, srq_enable_i;
  logic       lockout_i, rem_cmd_valid_i, rem_cmd_arg_i, trig_cmd_i;
  logic [1:0] trig_source_i;
  logic       ext_trig_i, key_accept_o, trigger_o, dev_clear_o, remote_o;
  logic       talker_o, listener_o, spoll_o;
  logic       atn_o, dav_o, nrfd_o, ndac_o, eoi_o;
  int         failures, n_tests, cyc, n_key, n_trg, n_clr;

  // Open-drain lines with pull-ups
  assign dio_n_i  = ~(dio_oe_o | dio_o);
  assign dav_n_i  = ~(dav_oe_o | dav_o);
  assign nrfd_n_i = ~(nrfd_oe_o | nrfd_o);
  assign ndac_n_i = ~(ndac_oe_o | ndac_o);
  assign eoi_n_i  = ~(eoi_oe_o | eoi_o);
  assign srq_n_i  = ~srq_oe_o;
  assign atn_n_i  = ~atn_o;

  gpibtl_port DUT (.*);
  gpibtl_host u_host (.*);

  initial clk_i = 1'b0;
  always #50 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cyc++;
    if (key_accept_o === 1'b1) n_key++;
    if (trigger_o === 1'b1) n_trg++;
    if (dev_clear_o === 1'b1) n_clr++;
    if (cyc == 60000) begin
      failures++;
      $display("CHECK FAILED %0t timeout", $time);
      results();
    end
  end

  task chk(input logic [8:0] got, input logic [8:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk

  task results;
    $display("failures %0d checks %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task key(input logic loc);
    key_valid_i <= 1'b1;
    key_local_i <= loc;
    @(posedge clk_i);
    key_valid_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : key

  task rem(input logic a);
    rem_cmd_valid_i <= 1'b1;
    rem_cmd_arg_i   <= a;
    @(posedge clk_i);
    rem_cmd_valid_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : rem

  // Listen, fill the receive buffer until held off, then drain it
  task t_listen;
    int i;
    ren_n_i    <= 1'b0;
    rx_ready_i <= 1'b0;
    u_host.put({3'h1, ADDR}, 1'b1, 1'b0);
    for (i = 0; i < 8; i++) u_host.put(8'(8'ha0 + i), 1'b0, i == 7);
    chk(listener_o, 1, "listener");
    chk(remote_o, 1, "remote by bus");
    repeat (30) @(posedge clk_i);
    chk(nrfd_oe_o, 1, "full buffer holds off");
    i = 0;
    fork
      u_host.put(8'hb9, 1'b0, 1'b0);
      begin
        rx_ready_i <= 1'b1;
        while (i < 9) begin
          @(posedge clk_i);
          if (rx_valid_o === 1'b1) begin
            chk({rx_end_o, rx_data_o},
                {i == 7, (i < 8) ? 8'(8'ha0 + i) : 8'hb9}, "rx");
            i++;
          end
        end
      end
    join
    chk(rx_valid_o, 0, "buffer empty");
  endtask : t_listen

  // Talk two bytes, slow then prompt acceptor, then own listen address
  task t_talk;
    logic [7:0] b;
    logic       e;
    int         i;
    u_host.put({3'h2, ADDR}, 1'b1, 1'b0);
    for (i = 0; i < 2; i++) begin
      fork
        u_host.get(b, e, 6 - 6 * i);
        begin
          tx_data_i  <= 8'h5a ^ 8'(i);
          tx_valid_i <= 1'b1;
          @(posedge clk_i);
          while (tx_ready_o !== 1'b1) @(posedge clk_i);
          tx_valid_i <= 1'b0;
        end
      join
      chk({e, b}, {1'b1, 8'h5a ^ 8'(i)}, "tx byte");
    end
    chk({talker_o, listener_o}, 2'b10, "talk unlistens");
    u_host.put({3'h1, ADDR}, 1'b1, 1'b0);
    chk({talker_o, listener_o}, 2'b01, "listen untalks");
  endtask : t_talk

  // Masked and enabled request, then a serial poll
  task t_poll;
    logic [7:0] b;
    logic       e;
    srq_cond_i <= 8'h04;
    repeat (4) @(posedge clk_i);
    chk(srq_oe_o, 0, "masked request");
    srq_enable_i <= 8'h04;
    repeat (3) @(posedge clk_i);
    chk(srq_oe_o, 1, "request line");
    u_host.put({1'b0, gpibtl_pkg::CMD_SPE}, 1'b1, 1'b0);
    u_host.put({3'h2, ADDR}, 1'b1, 1'b0);
    u_host.get(b, e, 0);
    chk({spoll_o, b}, {1'b1, STB | 8'h40}, "poll status");
    repeat (3) @(posedge clk_i);
    chk(srq_oe_o, 0, "request released");
    u_host.get(b, e, 0);
    chk(b, STB, "poll status again");
    u_host.put({1'b0, gpibtl_pkg::CMD_SPD}, 1'b1, 1'b0);
    chk(spoll_o, 0, "poll off");
    u_host.put({1'b0, gpibtl_pkg::CMD_UNT}, 1'b1, 1'b0);
  endtask : t_poll

  // Keys in remote and local, lockout, go-to-local, remote command
  task t_remote;
    int k;
    k = n_key;
    lockout_i <= 1'b1;
    key(1'b0);
    key(1'b1);
    chk(9'(n_key - k), 0, "keys in remote");
    chk(remote_o, 1, "lockout holds remote");
    u_host.put({1'b0, gpibtl_pkg::CMD_GTL}, 1'b1, 1'b0);
    chk(remote_o, 1, "go to local ignored");
    rem(1'b0);
    chk(remote_o, 0, "remote off");
    key(1'b0);
    chk(9'(n_key - k), 1, "key in local");
    rem(1'b1);
    lockout_i <= 1'b0;
    key(1'b1);
    chk({remote_o, 8'(n_key - k)}, 9'h002, "local key");
  endtask : t_remote

  // Both clears, bus trigger, every trigger source
  task t_ctl;
    int i;
    int c;
    c = n_clr;
    u_host.put({1'b0, gpibtl_pkg::CMD_DCL}, 1'b1, 1'b0);
    chk(9'(n_clr - c), 1, "universal clear");
    u_host.put({3'h1, ADDR}, 1'b1, 1'b0);
    u_host.put({1'b0, gpibtl_pkg::CMD_SDC}, 1'b1, 1'b0);
    chk(9'(n_clr - c), 2, "selected clear");
    trig_source_i <= gpibtl_pkg::TRIG_SRC_BUS;
    c = n_trg;
    u_host.put({1'b0, gpibtl_pkg::CMD_GET}, 1'b1, 1'b0);
    chk(9'(n_trg - c), 1, "bus trigger message");
    u_host.put({1'b0, gpibtl_pkg::CMD_UNL}, 1'b1, 1'b0);
    chk(listener_o, 0, "unlisten");
    for (i = 0; i < 3; i++) begin
      c = n_trg;
      trig_source_i <= 2'(i);
      trig_cmd_i    <= 1'b1;
      @(posedge clk_i);
      trig_cmd_i <= 1'b0;
      ext_trig_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      ext_trig_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk(9'(n_trg - c), 1, "trigger by source");
    end
  endtask : t_ctl

  initial begin
    {resetn_i, rx_ready_i, tx_valid_i, key_valid_i, key_local_i} = '0;
    {lockout_i, rem_cmd_valid_i, rem_cmd_arg_i, trig_cmd_i} = '0;
    {ext_trig_i, tx_data_i, srq_cond_i, srq_enable_i, trig_source_i} = '0;
    {ifc_n_i, ren_n_i, tx_end_i} = 3'h7;
    status_i = STB;
    addr_i   = ADDR;
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    chk({remote_o, talker_o, listener_o, spoll_o, srq_oe_o, dav_oe_o},
        0, "reset state");
    repeat (2) @(posedge clk_i);
    t_listen;
    t_talk;
    t_poll;
    t_remote;
    t_ctl;
    results();
  end
endmodule : testbench

bind gpibtl_port gpibtl_chk u_chk (.*);
